// ==== dv/fdcr_nvm_model.sv ====
module fdcr_nvm_model #(
   parameter fdcr_pkg::fdcr_cfg_t IMAGE = '0
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          req,
   input  wire logic [3:0]    delay,
   output fdcr_pkg::fdcr_cfg_t image,
   output logic               valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       pend;
   logic [3:0] cnt;
   // one restore at a time; a new request restarts the wait
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend  <= 1'b0;
         cnt   <= 4'h0;
         valid <= 1'b0;
      end else begin
         valid <= 1'b0;
         if (req) begin
            pend <= 1'b1;
            cnt  <= delay;
         end else if (pend && cnt == 4'h0) begin
            pend  <= 1'b0;
            valid <= 1'b1;
         end else if (pend) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
   // outside the valid cycle the bytes are junk, so a late sample shows up
   assign image = valid ? IMAGE : ~IMAGE;
endmodule

// ==== dv/tb.sv ====
`include "fdcr_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [15:0] a;
      logic [7:0]  w;
      logic [7:0]  r;
   } fdcr_row_t;
   localparam fdcr_pkg::fdcr_cfg_t RST = 64'h1563_1965_008b_6f01;
   localparam fdcr_pkg::fdcr_cfg_t TBL = 64'hff00_7f80_ff7f_0f07;
   localparam fdcr_pkg::fdcr_cfg_t IMG = 64'h2040_1090_8505_3cfd;
   localparam logic [7:0] PID = 8'h5a; // arbitrary value
   logic                    clk;
   logic                    nrst;
   fdcr_pkg::fdcr_acc_t     acc;
   logic [7:0]              rdata;
   logic                    rvalid;
   fdcr_pkg::fdcr_cfg_t     nvm_image;
   logic                    nvm_valid;
   logic                    nvm_restore_req;
   logic                    restore_busy;
   logic                    recompute_done;
   fdcr_pkg::fdcr_derived_t derived;
   logic [3:0]              nvm_delay;
   int                      failures;
   int                      cmp_count;
   fdcr_row_t               rows [16];
   fdcr_regs #(.PART_ID(PID)) uut (.clk(clk), .nrst(nrst), .acc(acc), .rdata(rdata),
      .rvalid(rvalid), .nvm_image(nvm_image), .nvm_valid(nvm_valid),
      .nvm_restore_req(nvm_restore_req), .restore_busy(restore_busy),
      .recompute_done(recompute_done), .derived(derived));
   fdcr_nvm_model #(.IMAGE(IMG)) nvm (.clk(clk), .nrst(nrst), .req(nvm_restore_req),
      .delay(nvm_delay), .image(nvm_image), .valid(nvm_valid));
   function automatic int lin(input int code, input int lo, input int hi, input int span);
      return lo + code * (hi - lo) / span;
   endfunction
   function automatic logic [7:0] ang(input logic [7:0] v);
      return v[7] ? {1'b0, v[6:0]} : 8'(-int'(v[6:0]));
   endfunction
   function automatic fdcr_pkg::fdcr_derived_t exp_der(input fdcr_pkg::fdcr_cfg_t c);
      fdcr_pkg::fdcr_derived_t d;
      d.floor_rpm = 16'(lin(c.speed_floor, `FDCR_FLOOR_RPM_LO, `FDCR_FLOOR_RPM_HI, 255));
      d.ceiling_rpm = 16'(lin(c.speed_ceiling, `FDCR_CEIL_RPM_LO, `FDCR_CEIL_RPM_HI, 255));
      d.duty_floor = c.input_duty_floor;
      d.duty_ceiling = c.input_duty_ceiling;
      d.advance_angle_at_floor_speed = ang(c.advance_angle_slow);
      d.advance_angle_at_ceiling_speed = ang(c.advance_angle_fast);
      d.soft_commutation_width_fast = 9'(lin(c.soft_commutation_widths[7:4], 29, 469, 15));
      d.soft_commutation_width_slow = 9'(lin(c.soft_commutation_widths[3:0], 29, 469, 15));
      d.speed_command_polarity = c.drive_polarity_scheme[2];
      d.bridge_switching_scheme = fdcr_pkg::fdcr_bridge_t'(c.drive_polarity_scheme[1:0]);
      return d;
   endfunction
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access at a time, as on a one-to-one serial link
   task automatic wr(input logic [15:0] a, input logic [7:0] w);
      @(posedge clk);
      acc <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
      @(posedge clk);
      acc <= '0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      acc <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      acc <= '0;
      #1;
      chk({rvalid, rdata}, {1'b1, e});
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end
   initial begin
      nrst = 1'b0;
      acc = '0;
      nvm_delay = 4'h0;
      failures = 0;
      cmp_count = 0;
      rows = '{'{16'h0000, 8'h00, 8'haa}, '{16'h0001, 8'hff, 8'h55},
               '{16'h0005, 8'h00, PID},   '{16'h0002, 8'hff, 8'h03},
               '{16'h0002, 8'hfc, 8'h00}, '{16'h0003, 8'h00, 8'h00},
               '{16'h0004, 8'h00, 8'h00}, '{16'h0200, 8'hff, 8'h00},
               '{16'h0100, 8'hff, 8'hff}, '{16'h0101, 8'h00, 8'h00},
               '{16'h0102, 8'h7f, 8'h7f}, '{16'h0103, 8'h80, 8'h80},
               '{16'h0104, 8'hff, 8'hff}, '{16'h0105, 8'h7f, 8'h7f},
               '{16'h0106, 8'h0f, 8'h0f}, '{16'h0107, 8'hff, 8'h07}};
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk({rvalid, rdata, restore_busy, recompute_done, nvm_restore_req}, 12'h000);
      chk(derived, exp_der(RST));
      rd_chk(16'h0002, 8'h00);
      for (int i = 0; i < 8; i++) begin
         rd_chk(16'h0100 + 16'(i), RST[63 - 8 * i -: 8]);
      end
      for (int i = 0; i < 16; i++) begin
         wr(rows[i].a, rows[i].w);
         rd_chk(rows[i].a, rows[i].r);
      end
      // recompute trigger without its permit leaves no trace
      wr(16'h0004, 8'h01);
      #1;
      chk(recompute_done, 1'b0);
      chk(derived, exp_der(RST));
      wr(16'h0002, 8'h02);
      wr(16'h0004, 8'h01);
      #1;
      chk(recompute_done, 1'b1);
      chk(derived, exp_der(TBL));
      @(posedge clk);
      #1;
      chk(recompute_done, 1'b0);
      rd_chk(16'h0004, 8'h00);
      wr(16'h0003, 8'h01);
      #1;
      chk({nvm_restore_req, restore_busy}, 2'b00);
      wr(16'h0002, 8'h03);
      // prompt and slow memory answers
      for (int k = 0; k < 2; k++) begin
         nvm_delay <= k ? 4'h6 : 4'h0;
         wr(16'h0100, 8'h00);
         wr(16'h0003, 8'h01);
         #1;
         chk({nvm_restore_req, restore_busy}, 2'b11);
         // a second trigger while the memory is still busy is dropped
         if (k) begin
            wr(16'h0003, 8'h01);
            #1;
            chk({nvm_restore_req, restore_busy}, 2'b01);
         end
         for (int n = 0; n < 20 && restore_busy !== 1'b0; n++) begin
            @(posedge clk);
            #1;
         end
         chk(restore_busy, 1'b0);
         rd_chk(16'h0003, 8'h00);
         for (int i = 0; i < 8; i++) begin
            rd_chk(16'h0100 + 16'(i), IMG[63 - 8 * i -: 8] & (i == 7 ? 8'h07 : 8'hff));
         end
         chk(derived, exp_der(TBL));
      end
      // negative floor angle and the two schemes nothing else selects
      wr(16'h0104, 8'h23);
      for (int k = 0; k < 2; k++) begin
         wr(16'h0107, k ? 8'h02 : 8'h00);
         wr(16'h0004, 8'h01);
         #1;
         chk(derived, exp_der({IMG[63:32], 8'h23, IMG[23:8], 6'h00, k[0], 1'b0}));
      end
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(derived, exp_der(RST));
      chk({rvalid, rdata, restore_busy, recompute_done, nvm_restore_req}, 12'h000);
      @(posedge clk);
      nrst <= 1'b1;
      rd_chk(16'h0002, 8'h00);
      rd_chk(16'h0100, 8'h15);
      tally_and_finish();
   end
endmodule

// ==== logic/fdcr_regs.sv ====
// Behaviour
// - offset 0x0000 reads constant 0xaa, writes ignored
// - offset 0x0001 reads constant 0x55, writes ignored
// - permit bit 1 gates recomputation of derived settings
// - permit bit 0 gates restore from nonvolatile memory
// - writing 1 to 0x0003 bit 0 restores when permitted; self-clearing
// - writing 1 to 0x0004 bit 0 recomputes when permitted; self-clearing
// - offset 0x0005 reads eight-bit part identifier, writes ignored
// - speed codes map linearly: floor 0..10400 rpm, ceiling 300..36000 rpm
// - low duty threshold spans 0% to 49.8% over codes 0x00..0x7f
// - high duty threshold spans 50.2% to 100% over codes 0x80..0xff
// - floor advance angle is sign-magnitude, bit 7 set means positive
// - ceiling advance angle at 0x0105 uses same sign-magnitude code
// - bits 7:4 at 0x0106 give fast soft width, 2.9% to 46.9%
// - bits 3:0 at 0x0106 give slow soft width, same scale
// - bit 2 at 0x0107 inverts command polarity
// - bits 1:0 at 0x0107 select bridge switching scheme
// - unimplemented bits ignore writes and read as zero
// - one host at a time on a one-to-one serial link
`include "fdcr_consts.svh"

module fdcr_regs #(
   parameter logic [7:0] PART_ID = `FDCR_PART_ID_DEFAULT // arbitrary value
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire fdcr_pkg::fdcr_acc_t     acc,
   output logic [7:0]                   rdata,
   output logic                         rvalid,
   input  wire fdcr_pkg::fdcr_cfg_t     nvm_image,
   input  wire logic                    nvm_valid,
   output logic                         nvm_restore_req,
   output logic                         restore_busy,
   output logic                         recompute_done,
   output fdcr_pkg::fdcr_derived_t      derived
);

   function automatic logic [15:0] fdcr_lin(input logic [7:0] code,
                                            input int unsigned lo,
                                            input int unsigned hi,
                                            input int unsigned span);
      int unsigned v;
      v = lo + (int'(code) * (hi - lo)) / span;
      return v[15:0];
   endfunction

   // sign-magnitude to two's complement, bit 7 clear is negative
   function automatic logic signed [7:0] fdcr_angle(input logic [7:0] code);
      logic [7:0] mag;
      mag = {1'b0, code[`FDCR_MAG_FIELD]};
      return code[`FDCR_SIGN_BIT] ? mag : 8'(-mag);
   endfunction

   function automatic fdcr_pkg::fdcr_derived_t fdcr_derive(input fdcr_pkg::fdcr_cfg_t c);
      fdcr_pkg::fdcr_derived_t d;
      logic [15:0]             wf;
      logic [15:0]             ws;
      d.floor_rpm = fdcr_lin(c.speed_floor, `FDCR_FLOOR_RPM_LO,
                             `FDCR_FLOOR_RPM_HI, `FDCR_CODE8_SPAN);
      d.ceiling_rpm = fdcr_lin(c.speed_ceiling, `FDCR_CEIL_RPM_LO,
                               `FDCR_CEIL_RPM_HI, `FDCR_CODE8_SPAN);
      // duty thresholds pass through as 1/255 steps of full duty
      d.duty_floor = c.input_duty_floor;
      d.duty_ceiling = c.input_duty_ceiling;
      d.advance_angle_at_floor_speed = fdcr_angle(c.advance_angle_slow);
      d.advance_angle_at_ceiling_speed = fdcr_angle(c.advance_angle_fast);
      wf = fdcr_lin({4'h0, c.soft_commutation_widths[`FDCR_SSW_FAST_FIELD]}, `FDCR_SSW_LO_PERMILLE,
                    `FDCR_SSW_HI_PERMILLE, `FDCR_SSW_SPAN);
      ws = fdcr_lin({4'h0, c.soft_commutation_widths[`FDCR_SSW_SLOW_FIELD]}, `FDCR_SSW_LO_PERMILLE,
                    `FDCR_SSW_HI_PERMILLE, `FDCR_SSW_SPAN);
      d.soft_commutation_width_fast = wf[8:0];
      d.soft_commutation_width_slow = ws[8:0];
      d.speed_command_polarity = c.drive_polarity_scheme[`FDCR_POLARITY_BIT];
      d.bridge_switching_scheme =
         fdcr_pkg::fdcr_bridge_t'(c.drive_polarity_scheme[`FDCR_SCHEME_FIELD]);
      return d;
   endfunction

   localparam fdcr_pkg::fdcr_cfg_t CFG_RST = '{
      speed_floor:             `FDCR_RST_SPEED_FLOOR,
      speed_ceiling:           `FDCR_RST_SPEED_CEIL,
      input_duty_floor:        `FDCR_RST_DUTY_FLOOR,
      input_duty_ceiling:      `FDCR_RST_DUTY_CEIL,
      advance_angle_slow:      `FDCR_RST_ANGLE_SLOW,
      advance_angle_fast:      `FDCR_RST_ANGLE_FAST,
      soft_commutation_widths: `FDCR_RST_SSW,
      drive_polarity_scheme:   `FDCR_RST_POLSCH
   };
   localparam fdcr_pkg::fdcr_derived_t DERIVED_RST = fdcr_derive(CFG_RST);

   // ---------------- register file and restore sequencing
   fdcr_pkg::fdcr_cfg_t   cfg_reg;
   fdcr_pkg::fdcr_cfg_t   cfg_next;
   logic [7:0]            permits_reg;
   logic [7:0]            permits_next;
   fdcr_pkg::fdcr_state_t state_reg;
   fdcr_pkg::fdcr_state_t state_next;
   logic                  restore_req_reg;
   logic                  restore_req_next;
   logic                  restore_go;
   logic                  recomp_go;

   // permits are taken from the register, so a permit written in the
   // same cycle as its trigger does not yet count
   assign restore_go = acc.wr && acc.addr == `FDCR_OFS_RESTORE
                       && acc.wdata[`FDCR_TRIGGER_BIT]
                       && permits_reg[`FDCR_RESTORE_PERMIT];
   assign recomp_go = acc.wr && acc.addr == `FDCR_OFS_RECOMP
                      && acc.wdata[`FDCR_TRIGGER_BIT]
                      && permits_reg[`FDCR_RECOMP_PERMIT];

   always_comb begin
      cfg_next = cfg_reg;
      permits_next = permits_reg;
      state_next = state_reg;
      restore_req_next = 1'b0;
      if (acc.wr) begin
         unique case (acc.addr)
            `FDCR_OFS_PERMITS:     permits_next = acc.wdata & `FDCR_PERMITS_MASK;
            `FDCR_OFS_SPEED_FLOOR: cfg_next.speed_floor = acc.wdata;
            `FDCR_OFS_SPEED_CEIL:  cfg_next.speed_ceiling = acc.wdata;
            `FDCR_OFS_DUTY_FLOOR:  cfg_next.input_duty_floor = acc.wdata;
            `FDCR_OFS_DUTY_CEIL:   cfg_next.input_duty_ceiling = acc.wdata;
            `FDCR_OFS_ANGLE_SLOW:  cfg_next.advance_angle_slow = acc.wdata;
            `FDCR_OFS_ANGLE_FAST:  cfg_next.advance_angle_fast = acc.wdata;
            `FDCR_OFS_SSW:         cfg_next.soft_commutation_widths = acc.wdata;
            `FDCR_OFS_POLSCH:
               cfg_next.drive_polarity_scheme = acc.wdata & `FDCR_POLSCH_MASK;
            // fixed, identifier, trigger and unmapped offsets store nothing
            default: ;
         endcase
      end
      unique case (state_reg)
         fdcr_pkg::FDCR_ST_IDLE: begin
            if (restore_go) begin
               state_next = fdcr_pkg::FDCR_ST_RESTORE;
               restore_req_next = 1'b1;
            end
         end
         fdcr_pkg::FDCR_ST_RESTORE: begin
            // memory image wins over a host write landing in the same cycle
            if (nvm_valid) begin
               cfg_next = nvm_image;
               cfg_next.drive_polarity_scheme =
                  nvm_image.drive_polarity_scheme & `FDCR_POLSCH_MASK;
               state_next = fdcr_pkg::FDCR_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_reg <= CFG_RST;
         permits_reg <= `FDCR_RST_PERMITS;
         state_reg <= fdcr_pkg::FDCR_ST_IDLE;
         restore_req_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         permits_reg <= permits_next;
         state_reg <= state_next;
         restore_req_reg <= restore_req_next;
      end
   end

   // ---------------- derived settings, updated only by an accepted trigger
   fdcr_pkg::fdcr_derived_t derived_reg;
   fdcr_pkg::fdcr_derived_t derived_next;
   logic                    recomp_done_reg;
   logic                    recomp_done_next;
   logic                    busy_reg;
   logic                    busy_next;

   always_comb begin
      derived_next = recomp_go ? fdcr_derive(cfg_reg) : derived_reg;
      recomp_done_next = recomp_go;
      busy_next = (state_next == fdcr_pkg::FDCR_ST_RESTORE);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         derived_reg <= DERIVED_RST;
         recomp_done_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         derived_reg <= derived_next;
         recomp_done_reg <= recomp_done_next;
         busy_reg <= busy_next;
      end
   end

   // ---------------- read path, answered one cycle after the request
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;
   logic       rvalid_next;

   always_comb begin
      rvalid_next = acc.rd;
      rdata_next = rdata_reg;
      if (acc.rd) begin
         unique case (acc.addr)
            `FDCR_OFS_CHECK_A:     rdata_next = `FDCR_CHECK_A;
            `FDCR_OFS_CHECK_B:     rdata_next = `FDCR_CHECK_B;
            `FDCR_OFS_PERMITS:     rdata_next = permits_reg;
            `FDCR_OFS_PART_ID:     rdata_next = PART_ID;
            `FDCR_OFS_SPEED_FLOOR: rdata_next = cfg_reg.speed_floor;
            `FDCR_OFS_SPEED_CEIL:  rdata_next = cfg_reg.speed_ceiling;
            `FDCR_OFS_DUTY_FLOOR:  rdata_next = cfg_reg.input_duty_floor;
            `FDCR_OFS_DUTY_CEIL:   rdata_next = cfg_reg.input_duty_ceiling;
            `FDCR_OFS_ANGLE_SLOW:  rdata_next = cfg_reg.advance_angle_slow;
            `FDCR_OFS_ANGLE_FAST:  rdata_next = cfg_reg.advance_angle_fast;
            `FDCR_OFS_SSW:         rdata_next = cfg_reg.soft_commutation_widths;
            `FDCR_OFS_POLSCH:      rdata_next = cfg_reg.drive_polarity_scheme;
            // triggers self-clear so they always read back zero
            default:               rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign rdata = rdata_reg;
   assign rvalid = rvalid_reg;
   assign nvm_restore_req = restore_req_reg;
   assign restore_busy = busy_reg;
   assign recompute_done = recomp_done_reg;
   assign derived = derived_reg;

   // ---------------- assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   check_a_read_a: assert property (
      acc.rd && acc.addr == `FDCR_OFS_CHECK_A |=> rvalid && rdata == `FDCR_CHECK_A)
      else $error("check pattern a wrong");

   check_b_read_a: assert property (
      acc.rd && acc.addr == `FDCR_OFS_CHECK_B |=> rvalid && rdata == `FDCR_CHECK_B)
      else $error("check pattern b wrong");

   part_id_read_a: assert property (
      acc.rd && acc.addr == `FDCR_OFS_PART_ID |=> rdata == PART_ID)
      else $error("part identifier wrong");

   restore_gated_a: assert property (
      acc.wr && acc.addr == `FDCR_OFS_RESTORE && !permits_reg[`FDCR_RESTORE_PERMIT]
      && state_reg == fdcr_pkg::FDCR_ST_IDLE |=> !nvm_restore_req && !restore_busy)
      else $error("restore started without permit");

   restore_pulse_a: assert property (
      restore_go && state_reg == fdcr_pkg::FDCR_ST_IDLE
      |=> nvm_restore_req ##1 !nvm_restore_req)
      else $error("restore request not a single pulse");

   recomp_gated_a: assert property (
      acc.wr && acc.addr == `FDCR_OFS_RECOMP && !permits_reg[`FDCR_RECOMP_PERMIT]
      |=> !recompute_done && $stable(derived))
      else $error("recompute ran without permit");

   recomp_result_a: assert property (
      recomp_go |=> recompute_done && derived == fdcr_derive($past(cfg_reg)))
      else $error("recompute result wrong");

   trigger_zero_a: assert property (
      acc.rd && (acc.addr == `FDCR_OFS_RESTORE || acc.addr == `FDCR_OFS_RECOMP)
      |=> rdata == 8'h00)
      else $error("trigger reads nonzero");

   polsch_mask_a: assert property (
      acc.wr && acc.addr == `FDCR_OFS_POLSCH && state_reg == fdcr_pkg::FDCR_ST_IDLE
      |=> cfg_reg.drive_polarity_scheme == ($past(acc.wdata) & `FDCR_POLSCH_MASK))
      else $error("unimplemented bits stored");

   angle_sign_a: assert property (
      recomp_go && !cfg_reg.advance_angle_slow[`FDCR_SIGN_BIT]
      && cfg_reg.advance_angle_slow[`FDCR_MAG_FIELD] != '0
      |=> derived.advance_angle_at_floor_speed < 0)
      else $error("floor angle sign wrong");

   angle_slow_pos_a: assert property (
      recomp_go && cfg_reg.advance_angle_slow[`FDCR_SIGN_BIT]
      |=> derived.advance_angle_at_floor_speed >= 0)
      else $error("floor angle not positive");

   angle_fast_neg_a: assert property (
      recomp_go && !cfg_reg.advance_angle_fast[`FDCR_SIGN_BIT]
      && cfg_reg.advance_angle_fast[`FDCR_MAG_FIELD] != '0
      |=> derived.advance_angle_at_ceiling_speed < 0)
      else $error("ceiling angle sign wrong");

   permits_mask_a: assert property (
      acc.wr && acc.addr == `FDCR_OFS_PERMITS
      |=> permits_reg == ($past(acc.wdata) & `FDCR_PERMITS_MASK))
      else $error("unimplemented permit bits stored");

   read_answer_a: assert property (
      acc.rd |=> rvalid)
      else $error("read not answered");

   rdata_hold_a: assert property (
      !acc.rd |=> $stable(rdata) && !rvalid)
      else $error("read data moved without read");

   busy_hold_a: assert property (
      restore_busy && !nvm_valid |=> restore_busy)
      else $error("restore ended early");

   busy_end_a: assert property (
      restore_busy && nvm_valid |=> !restore_busy
      && cfg_reg.speed_floor == $past(nvm_image.speed_floor))
      else $error("restore image not taken");

   busy_refuse_a: assert property (
      restore_busy |=> !nvm_restore_req)
      else $error("restore restarted while busy");

   recomp_quiet_a: assert property (
      !recomp_go |=> !recompute_done && $stable(derived))
      else $error("derived changed without trigger");

   floor_top_a: assert property (
      recomp_go && cfg_reg.speed_floor == '1
      |=> derived.floor_rpm == `FDCR_FLOOR_RPM_HI)
      else $error("floor speed end point wrong");

   ceil_bottom_a: assert property (
      recomp_go && cfg_reg.speed_ceiling == '0
      |=> derived.ceiling_rpm == `FDCR_CEIL_RPM_LO)
      else $error("ceiling speed end point wrong");

   width_range_a: assert property (
      recomp_go |=> derived.soft_commutation_width_fast >= `FDCR_SSW_LO_PERMILLE
      && derived.soft_commutation_width_fast <= `FDCR_SSW_HI_PERMILLE
      && derived.soft_commutation_width_slow >= `FDCR_SSW_LO_PERMILLE
      && derived.soft_commutation_width_slow <= `FDCR_SSW_HI_PERMILLE)
      else $error("soft width out of range");

   duty_pass_a: assert property (
      recomp_go |=> derived.duty_floor == $past(cfg_reg.input_duty_floor)
      && derived.duty_ceiling == $past(cfg_reg.input_duty_ceiling))
      else $error("duty threshold not passed on");

   polsch_pass_a: assert property (
      recomp_go |=> derived.speed_command_polarity
      == $past(cfg_reg.drive_polarity_scheme[`FDCR_POLARITY_BIT])
      && derived.bridge_switching_scheme
      == $past(cfg_reg.drive_polarity_scheme[`FDCR_SCHEME_FIELD]))
      else $error("polarity or bridge scheme wrong");

endmodule

// ==== pkg/fdcr_consts.svh ====
`ifndef FDCR_CONSTS_SVH
`define FDCR_CONSTS_SVH

// register offsets
`define FDCR_OFS_CHECK_A      16'h0000
`define FDCR_OFS_CHECK_B      16'h0001
`define FDCR_OFS_PERMITS      16'h0002
`define FDCR_OFS_RESTORE      16'h0003
`define FDCR_OFS_RECOMP       16'h0004
`define FDCR_OFS_PART_ID      16'h0005
`define FDCR_OFS_SPEED_FLOOR  16'h0100
`define FDCR_OFS_SPEED_CEIL   16'h0101
`define FDCR_OFS_DUTY_FLOOR   16'h0102
`define FDCR_OFS_DUTY_CEIL    16'h0103
`define FDCR_OFS_ANGLE_SLOW   16'h0104
`define FDCR_OFS_ANGLE_FAST   16'h0105
`define FDCR_OFS_SSW          16'h0106
`define FDCR_OFS_POLSCH       16'h0107

// fixed patterns and reset values
`define FDCR_CHECK_A          8'haa
`define FDCR_CHECK_B          8'h55
`define FDCR_PART_ID_DEFAULT  8'h3c
`define FDCR_RST_PERMITS      8'h00
`define FDCR_RST_SPEED_FLOOR  8'h15
`define FDCR_RST_SPEED_CEIL   8'h63
`define FDCR_RST_DUTY_FLOOR   8'h19
`define FDCR_RST_DUTY_CEIL    8'h65
`define FDCR_RST_ANGLE_SLOW   8'h00
`define FDCR_RST_ANGLE_FAST   8'h8b
`define FDCR_RST_SSW          8'h6f
`define FDCR_RST_POLSCH       8'h01

// implemented bits and field positions
`define FDCR_PERMITS_MASK     8'h03
`define FDCR_POLSCH_MASK      8'h07
`define FDCR_RESTORE_PERMIT   0
`define FDCR_RECOMP_PERMIT    1
`define FDCR_TRIGGER_BIT      0
`define FDCR_SIGN_BIT         7
`define FDCR_POLARITY_BIT     2
`define FDCR_MAG_FIELD        6:0
`define FDCR_SSW_FAST_FIELD   7:4
`define FDCR_SSW_SLOW_FIELD   3:0
`define FDCR_SCHEME_FIELD     1:0

// linear code scales
`define FDCR_CODE8_SPAN       255
`define FDCR_FLOOR_RPM_LO     0
`define FDCR_FLOOR_RPM_HI     10400
`define FDCR_CEIL_RPM_LO      300
`define FDCR_CEIL_RPM_HI      36000
`define FDCR_SSW_SPAN         15
`define FDCR_SSW_LO_PERMILLE  29
`define FDCR_SSW_HI_PERMILLE  469

`endif

// ==== pkg/fdcr_pkg.sv ====
package fdcr_pkg;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } fdcr_acc_t;

   typedef struct packed {
      logic [7:0] speed_floor;
      logic [7:0] speed_ceiling;
      logic [7:0] input_duty_floor;
      logic [7:0] input_duty_ceiling;
      logic [7:0] advance_angle_slow;
      logic [7:0] advance_angle_fast;
      logic [7:0] soft_commutation_widths;
      logic [7:0] drive_polarity_scheme;
   } fdcr_cfg_t;

   typedef enum logic [1:0] {
      FDCR_HS_PWM_LS_ASYNC,
      FDCR_HS_PWM_LS_SYNC,
      FDCR_HS_ASYNC_LS_PWM,
      FDCR_HS_SYNC_LS_PWM
   } fdcr_bridge_t;

   typedef struct packed {
      logic [15:0]        floor_rpm;
      logic [15:0]        ceiling_rpm;
      logic [7:0]         duty_floor;
      logic [7:0]         duty_ceiling;
      logic signed [7:0]  advance_angle_at_floor_speed;
      logic signed [7:0]  advance_angle_at_ceiling_speed;
      logic [8:0]         soft_commutation_width_fast;
      logic [8:0]         soft_commutation_width_slow;
      logic               speed_command_polarity;
      fdcr_bridge_t       bridge_switching_scheme;
   } fdcr_derived_t;

   typedef enum logic {
      FDCR_ST_IDLE,
      FDCR_ST_RESTORE
   } fdcr_state_t;

endpackage
